/* File: hw/swb_pkg.sv */
package swb_pkg;

   // Mode pin encoding {mode_select_hi, mode_select_lo}
   typedef enum logic [1:0] {
      SWB_MODE_SLEEP  = 2'h0,
      SWB_MODE_HSPEED = 2'h1,
      SWB_MODE_WAKEUP = 2'h2,
      SWB_MODE_NORMAL = 2'h3
   } swb_mode_t;

   // Bus drive level encoding
   localparam logic [1:0] SWB_DRV_OFF    = 2'h0;
   localparam logic [1:0] SWB_DRV_NORMAL = 2'h1;
   localparam logic [1:0] SWB_DRV_HIGHV  = 2'h2;

   // Clock rate
   localparam int SWB_CLK_MHZ = 250;

   // Nominal timing figures
   localparam int SWB_TXTO_MS     = 17;
   localparam int SWB_WUF_MIN_US  = 10;
   localparam int SWB_WUF_MAX_US  = 70;
   localparam int SWB_SLEEP_MIN_MS = 100;
   localparam int SWB_SLEEP_TYP_MS = 250;
   localparam int SWB_SLEEP_MAX_MS = 500;

   // Derived cycle counts
   localparam int SWB_TXTO_CYC  = SWB_TXTO_MS * 1000 * SWB_CLK_MHZ;
   localparam int SWB_WUF_CYC   = SWB_WUF_MIN_US * SWB_CLK_MHZ;
   localparam int SWB_SLEEP_CYC = SWB_SLEEP_TYP_MS * 1000 * SWB_CLK_MHZ;

   // Synchroniser and FIFO
   localparam int SWB_SYNC_DEPTH = 3;
   localparam int SWB_FIFO_DEPTH = 8;
   localparam int SWB_FIFO_WIDTH = 1;

endpackage

/* File: hw/swb_fifo.sv */
`timescale 1ns/1ps
module swb_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wptr_reg, wptr_next;
   logic [AW-1:0]    rptr_reg, rptr_next;
   logic [AW:0]      cnt_reg,  cnt_next;
   logic             push, pop;

   // Handshakes qualified by honest full and empty
   always_comb begin
      push      = in_valid && (cnt_reg != (AW+1)'(DEPTH));
      pop       = out_ready && (cnt_reg != '0);
      wptr_next = push ? ((wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1) : wptr_reg;
      rptr_next = pop  ? ((rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1) : rptr_reg;
      cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rptr_reg];

   // Pointer registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg  <= '0;
      end else begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg  <= cnt_next;
      end
   end

   // Storage needs no reset; contents only read when counted valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wptr_reg] <= in_data;
      end
   end
endmodule // swb_fifo

/* File: hw/swb_core.sv */
`timescale 1ns/1ps
// Function
// R01 - Transmit high or floating leaves bus recessive
// R02 - Transmit low drives dominant, level per mode
// R03 - Sleep never drives the bus dominant
// R04 - Transmit pull-up only in active modes
// R05 - Stuck-low transmit switches driver off
// R06 - Next transmit rising edge resumes driving
// R07 - Mode inputs pulled down, default sleep
// R08 - Mode pins decode sleep/fast/wake/normal
// R09 - Sleep until high-voltage wake or mode change
// R10 - High-speed: shaping off, strong drive
// R11 - Normal: shaped edges, trailing-edge control
// R12 - Only high-voltage signalling wakes sleeping node
// R13 - Receive high recessive, low dominant; after standby, rx stays low until the first bus change
// R14 - Sleep blocks receive until wake or mode
// R15 - Bus wake signals host by receive low
// R16 - Back to sleep without mode change
// R17 - Active modes pass all bus changes
// R18 - Receive output undriven during sleep
// R19 - Load ground path closed except ground loss
// R20 - Transmit timeout typically 17 ms
// R21 - Wake accepted after filter time
// R22 - Standby-to-sleep timeout 100 to 500 ms
// R23 - Timeout counter restarts on transmit high
module swb_core
   import swb_pkg::*;
#(
   parameter int TXTO_CYC  = SWB_TXTO_CYC,
   parameter int WUF_CYC   = SWB_WUF_CYC,
   parameter int SLEEP_CYC = SWB_SLEEP_CYC,
   parameter int FIFO_DEPTH = SWB_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Controller side pins
   input  wire logic       tx_data,
   input  wire logic       mode_select_lo,
   input  wire logic       mode_select_hi,
   output logic            rx_data,
   output logic            rx_data_oe_n,
   // Pad control
   output logic            tx_pullup_en,
   output logic            mode_pulldown_en,
   output logic            hs_drive,
   output logic            shaping_en,
   // Bus line
   input  wire logic       bus_dominant,
   input  wire logic       high_voltage_wakeup,
   output logic [1:0]      bus_line_drive,
   // Ground supervision
   input  wire logic       ground_lost,
   output logic            load_path_closed,
   // Status
   output logic            standby,
   output logic            tx_timed_out
);
   // Counter widths sized to hold each terminal count
   localparam int TW = $clog2(TXTO_CYC + 1);
   localparam int WW = $clog2(WUF_CYC + 1);
   localparam int SW = $clog2(SLEEP_CYC + 1);

   // Three-stage synchronisers for every pin input
   localparam int NIN = 6;
   logic [NIN-1:0] pin_raw;
   logic [NIN-1:0] s1_reg, s2_reg, s3_reg, st_reg;
   logic [NIN-1:0] s1_next, s2_next, s3_next, st_next;
   assign pin_raw = {ground_lost, high_voltage_wakeup, bus_dominant,
                     mode_select_hi, mode_select_lo, tx_data};

   // A change counts only once stage two and three agree
   // Stage one is read only by stage two, to contain metastability
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_sync
         always_comb begin
            s1_next[gi] = pin_raw[gi];
            s2_next[gi] = s1_reg[gi];
            s3_next[gi] = s2_reg[gi];
            st_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : st_reg[gi];
         end
      end
   endgenerate

   // Stable reset values: tx idle high, mode sleep, bus idle
   // Idle levels at reset keep a false edge off the release
   localparam logic [NIN-1:0] SYNC_RST = 6'h01;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_reg <= SYNC_RST;
         s2_reg <= SYNC_RST;
         s3_reg <= SYNC_RST;
         st_reg <= SYNC_RST;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         st_reg <= st_next;
      end
   end

   // Stable pin copies; only these feed the logic below
   logic      tx_s, bus_dom_s, hv_s, gnd_lost_s;
   swb_mode_t mode_s;
   assign tx_s       = st_reg[0];
   assign mode_s     = swb_mode_t'({st_reg[2], st_reg[1]}); // R08
   assign bus_dom_s  = st_reg[3];
   assign hv_s       = st_reg[4];
   assign gnd_lost_s = st_reg[5];

   // Any mode other than sleep is active
   logic active;
   assign active = (mode_s != SWB_MODE_SLEEP);

   // Receive path through FIFO: stalls when drain side not ready
   // Drained every active cycle, so in practice it never fills
   logic rxf_in_ready, rxf_out_valid, rxf_out_data, rxf_pop;
   logic rx_last_reg, rx_last_next;
   swb_fifo #(
      .WIDTH (SWB_FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (active && (bus_dom_s == rx_last_reg)),
      .in_ready  (rxf_in_ready),
      .in_data   (!bus_dom_s),
      .out_valid (rxf_out_valid),
      .out_ready (rxf_pop),
      .out_data  (rxf_out_data)
   );

   // Core state
   // Each output has its own flop and next value
   typedef enum {ST_SLEEP, ST_STANDBY, ST_ACTIVE} swb_state_t;
   swb_state_t     state_reg, state_next;
   logic [TW-1:0]  txto_reg, txto_next;
   logic           to_reg, to_next;
   logic           tx_prev_reg, tx_prev_next;
   logic [WW-1:0]  wuf_reg, wuf_next;
   logic [SW-1:0]  slp_reg, slp_next;
   logic [1:0]     drv_reg, drv_next;
   logic           rx_reg, rx_next;
   logic           rxoe_reg, rxoe_next;
   logic           pu_reg, pu_next;
   logic           hs_reg, hs_next;
   logic           shp_reg, shp_next;
   logic           load_reg, load_next;
   logic           sb_reg, sb_next;
   logic           pd_reg, pd_next;

   // Next-state logic for mode, wake, timeout and pins
   always_comb begin
      state_next   = state_reg;
      txto_next    = txto_reg;
      to_next      = to_reg;
      tx_prev_next = tx_s;
      wuf_next     = '0;
      slp_next     = '0;
      rx_last_next = rx_last_reg;
      rxf_pop      = 1'b0;
      rx_next      = rx_reg;
      rxoe_next    = 1'b1;

      // Wake filter counts only high-voltage level
      // Any gap restarts the filter, so short pulses never wake
      if (state_reg == ST_SLEEP && hv_s) begin // R12
         wuf_next = (wuf_reg == WW'(WUF_CYC)) ? wuf_reg : wuf_reg + 1'b1; // R21
      end

      // Active mode pins always win over wake and sleep timer
      case (state_reg)
         ST_SLEEP: begin
            if (active) begin
               state_next = ST_ACTIVE; // R09
            end else if (wuf_reg == WW'(WUF_CYC)) begin
               state_next = ST_STANDBY; // R09 R21
            end
            // Receive parked recessive while its pin is released
            rx_next = 1'b1; // R14
         end
         ST_STANDBY: begin
            // Sleep timer runs only while standing by
            slp_next = slp_reg + 1'b1;
            rx_next  = 1'b0; // R15
            if (active) begin
               state_next = ST_ACTIVE;
            end else if (slp_reg == SW'(SLEEP_CYC - 1)) begin
               state_next = ST_SLEEP; // R16 R22
            end
         end
         ST_ACTIVE: begin
            // Dropping to sleep skips standby; only a bus wake enters it
            if (!active) begin
               state_next = ST_SLEEP;
            end
            // Forward every bus change in order
            rxf_pop = 1'b1; // R17
            if (rxf_out_valid) begin
               rx_next = rxf_out_data; // R13
            end
         end
         default: state_next = ST_SLEEP;
      endcase

      // Track last queued bus level
      if (active && rxf_in_ready && (bus_dom_s == rx_last_reg)) begin
         rx_last_next = !bus_dom_s;
      end
      if (!active) begin
         rx_last_next = 1'b1;
      end

      // Output enable low while driving; sleep leaves pin off
      rxoe_next = (state_next == ST_SLEEP); // R18

      // Stuck-low transmit timeout
      // Count saturates, so the cut is flagged once and then held
      if (!active || tx_s) begin
         txto_next = '0; // R23
      end else if (txto_reg != TW'(TXTO_CYC)) begin
         txto_next = txto_reg + 1'b1; // R23
      end
      if (txto_reg == TW'(TXTO_CYC - 1) && active && !tx_s) begin
         to_next = 1'b1; // R05 R20
      end
      // Transmit rising edge re-arms the driver at once
      if (tx_s && !tx_prev_reg) begin
         to_next = 1'b0; // R06
      end

      // Bus driver level
      // Timeout and sleep both override a low transmit request
      drv_next = SWB_DRV_OFF; // R01
      if (!tx_s && active && !to_next) begin
         drv_next = (mode_s == SWB_MODE_WAKEUP) ? SWB_DRV_HIGHV : SWB_DRV_NORMAL; // R02
      end
      if (!active) begin
         drv_next = SWB_DRV_OFF; // R03
      end

      // Pad controls follow the decoded mode every cycle; load path follows ground, standby follows state
      pu_next   = active; // R04
      hs_next   = (mode_s == SWB_MODE_HSPEED); // R10
      shp_next  = (mode_s != SWB_MODE_HSPEED); // R11
      load_next = !gnd_lost_s; // R19
      sb_next   = (state_next == ST_STANDBY);

      // Pull-downs stay on in every mode, so floating pins mean sleep
      pd_next   = 1'b1; // R07
   end

   // State registers
   // Synchronous reset puts every output at its idle level
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg   <= ST_SLEEP;
         txto_reg    <= '0;
         to_reg      <= 1'b0;
         tx_prev_reg <= 1'b1;
         wuf_reg     <= '0;
         slp_reg     <= '0;
         rx_last_reg <= 1'b1;
         drv_reg     <= SWB_DRV_OFF;
         rx_reg      <= 1'b1;
         rxoe_reg    <= 1'b1;
         pu_reg      <= 1'b0;
         hs_reg      <= 1'b0;
         shp_reg     <= 1'b1;
         load_reg    <= 1'b1;
         sb_reg      <= 1'b0;
         pd_reg      <= 1'b1;
      end else begin
         state_reg   <= state_next;
         txto_reg    <= txto_next;
         to_reg      <= to_next;
         tx_prev_reg <= tx_prev_next;
         wuf_reg     <= wuf_next;
         slp_reg     <= slp_next;
         rx_last_reg <= rx_last_next;
         drv_reg     <= drv_next;
         rx_reg      <= rx_next;
         rxoe_reg    <= rxoe_next;
         pu_reg      <= pu_next;
         hs_reg      <= hs_next;
         shp_reg     <= shp_next;
         load_reg    <= load_next;
         sb_reg      <= sb_next;
         pd_reg      <= pd_next;
      end
   end

   // Outputs straight from flops
   // No output is combinational, so pins never glitch
   assign bus_line_drive   = drv_reg;
   assign rx_data          = rx_reg;
   assign rx_data_oe_n     = rxoe_reg;
   assign tx_pullup_en     = pu_reg;
   assign mode_pulldown_en = pd_reg; // R07
   assign hs_drive         = hs_reg;
   assign shaping_en       = shp_reg;
   assign load_path_closed = load_reg;
   assign standby          = sb_reg;
   assign tx_timed_out     = to_reg;
endmodule // swb_core

/* File: verif/swb_core_chk.sv */
`timescale 1ns/1ps
module swb_core_chk
   import swb_pkg::*;
#(
   parameter int TXTO_CYC = SWB_TXTO_CYC
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // Controller pins
   input wire logic       tx_data,
   input wire logic       mode_select_lo,
   input wire logic       mode_select_hi,
   input wire logic       rx_data,
   input wire logic       rx_data_oe_n,
   // Pad control and bus
   input wire logic       tx_pullup_en,
   input wire logic       hs_drive,
   input wire logic       shaping_en,
   input wire logic [1:0] bus_line_drive,
   // Status
   input wire logic       standby,
   input wire logic       tx_timed_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   logic [1:0] mode;
   int         low_cnt_reg;
   int         low_cnt_next;
   assign mode = {mode_select_hi, mode_select_lo};

   // Pin-level count of tx low in an active mode; runs ahead of the design's synced copy
   always_comb begin
      low_cnt_next = (tx_data || mode == 2'h0) ? 0 : low_cnt_reg + 1;
   end
   always_ff @(posedge clk) begin
      low_cnt_reg <= rstn ? low_cnt_next : 0;
   end

   sequence s_mode_steady;
      $stable(mode)[*8];
   endsequence
   sequence s_tx_release;
      tx_timed_out ##0 $rose(tx_data);
   endsequence

   a_sleep_no_drive: assert property ((mode == 2'h0)[*8] |-> bus_line_drive == SWB_DRV_OFF)
      else $error("bus driven while sleep selected");
   a_tx_high_idle: assert property (tx_data[*8] |-> bus_line_drive == SWB_DRV_OFF)
      else $error("bus driven with tx high");
   a_pullup_mode: assert property (s_mode_steady |-> tx_pullup_en == (mode != 2'h0))
      else $error("tx pull-up does not follow mode");
   a_speed_mode: assert property (s_mode_steady |->
      hs_drive == (mode == SWB_MODE_HSPEED) && shaping_en == !hs_drive)
      else $error("drive strength or shaping wrong for mode");
   a_drive_level: assert property (($stable(mode) && !tx_data)[*8] |->
      low_cnt_reg >= TXTO_CYC || bus_line_drive == (mode == 2'h0 ? SWB_DRV_OFF :
      mode == SWB_MODE_WAKEUP ? SWB_DRV_HIGHV : SWB_DRV_NORMAL))
      else $error("dominant level wrong for mode");
   a_timeout_cut: assert property (low_cnt_reg > TXTO_CYC + 8 |->
      bus_line_drive == SWB_DRV_OFF && tx_timed_out)
      else $error("stuck tx not cut off");
   a_timeout_resume: assert property (s_tx_release |-> ##[1:8] !tx_timed_out)
      else $error("timeout not cleared by tx rise");
   a_wake_irq: assert property ($rose(standby) |-> ##[0:3] (!rx_data && !rx_data_oe_n))
      else $error("wake not signalled on rx");
endmodule // swb_core_chk

/* File: verif/swb_host_model.sv */
`timescale 1ns/1ps
module swb_host_model
   import swb_pkg::*;
(
   // Clock
   input  wire logic      clk,
   // Commands from the bench
   input  wire swb_mode_t cmd_mode,
   input  wire logic      cmd_tx,
   // Pins toward the transceiver
   output logic           tx_data,
   output logic           mode_select_lo,
   output logic           mode_select_hi,
   // Receive pin as the host sees it
   input  wire logic      rx_data,
   input  wire logic      rx_data_oe_n,
   output logic           rx_seen
);
   logic rx_last = 1'b1;

   // Host drives levels straight from its commands
   assign tx_data = cmd_tx;
   assign {mode_select_hi, mode_select_lo} = cmd_mode;

   // Released rx shows the inverse of its last driven level, so stale data never passes
   always @(posedge clk) begin
      if (!rx_data_oe_n) begin
         rx_last <= rx_data;
      end
   end
   assign rx_seen = rx_data_oe_n ? ~rx_last : rx_data;
endmodule // swb_host_model

/* File: verif/swb_core_tb.sv */
`timescale 1ns/1ps
module swb_core_tb
   import swb_pkg::*;
();
   localparam int TXTO = 50;
   localparam int WUF  = 20;
   localparam int SLP  = 200;

   logic       clk = 1'b0, rstn = 1'b0, cmd_tx = 1'b1;
   logic       bus_dominant = 1'b0, high_voltage_wakeup = 1'b0, ground_lost = 1'b0;
   swb_mode_t  cmd_mode = SWB_MODE_SLEEP;
   logic       tx_data, mode_select_lo, mode_select_hi, rx_data, rx_data_oe_n, rx_seen;
   logic       tx_pullup_en, mode_pulldown_en, hs_drive, shaping_en;
   logic       load_path_closed, standby, tx_timed_out;
   logic [1:0] bus_line_drive;
   int         n_mismatch = 0;
   int         checks_done = 0;

   // Free-running 250 MHz clock
   initial begin
      forever #2 clk = ~clk;
   end

   swb_host_model host (.clk, .cmd_mode, .cmd_tx, .tx_data, .mode_select_lo,
      .mode_select_hi, .rx_data, .rx_data_oe_n, .rx_seen);
   swb_core #(.TXTO_CYC(TXTO), .WUF_CYC(WUF), .SLEEP_CYC(SLP)) dut (.clk, .rstn, .tx_data,
      .mode_select_lo, .mode_select_hi, .rx_data, .rx_data_oe_n, .tx_pullup_en,
      .mode_pulldown_en, .hs_drive, .shaping_en, .bus_dominant, .high_voltage_wakeup,
      .bus_line_drive, .ground_lost, .load_path_closed, .standby, .tx_timed_out);

   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // Fixed waits cover the ~5-7 cycle pin-to-output latency
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic t_reset;
      chk(bus_line_drive, SWB_DRV_OFF);
      chk({rx_data_oe_n, standby}, 2'h2);
      chk({tx_pullup_en, mode_pulldown_en}, 2'h1);
      chk({1'b0, load_path_closed}, 2'h1);
   endtask

   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         cmd_mode = swb_mode_t'(m);
         cmd_tx = 1'b0;
         settle(12);
         chk(bus_line_drive, m == 0 ? SWB_DRV_OFF : m == 2 ? SWB_DRV_HIGHV : SWB_DRV_NORMAL);
         chk({tx_pullup_en, hs_drive}, {m != 0, m == 1});
         chk({shaping_en, rx_data_oe_n}, {m != 1, m == 0});
         cmd_tx = 1'b1;
         settle(12);
         chk(bus_line_drive, SWB_DRV_OFF);
      end
   endtask

   task automatic t_rx;
      for (int m = 1; m < 4; m++) begin
         cmd_mode = swb_mode_t'(m);
         bus_dominant = 1'b1;
         settle(12);
         chk({rx_data, rx_seen}, 2'h0);
         bus_dominant = 1'b0;
         settle(12);
         chk({rx_data, rx_seen}, 2'h3);
      end
      cmd_mode = SWB_MODE_SLEEP;
      bus_dominant = 1'b1;
      settle(30);
      chk({rx_data_oe_n, standby}, 2'h2);
      bus_dominant = 1'b0;
   endtask

   task automatic t_timeout;
      cmd_mode = SWB_MODE_NORMAL;
      cmd_tx = 1'b0;
      settle(TXTO - 12);
      cmd_tx = 1'b1;
      settle(8);
      cmd_tx = 1'b0;
      settle(TXTO - 12);
      chk(bus_line_drive, SWB_DRV_NORMAL);
      settle(30);
      chk(bus_line_drive, SWB_DRV_OFF);
      chk({1'b0, tx_timed_out}, 2'h1);
      cmd_tx = 1'b1;
      settle(8);
      cmd_tx = 1'b0;
      settle(8);
      chk(bus_line_drive, SWB_DRV_NORMAL);
      cmd_tx = 1'b1;
      settle(12);
   endtask

   task automatic t_wake;
      cmd_mode = SWB_MODE_SLEEP;
      settle(12);
      {bus_dominant, high_voltage_wakeup} = 2'h3;
      settle(WUF / 2);
      {bus_dominant, high_voltage_wakeup} = 2'h0;
      settle(12);
      chk({standby, rx_data_oe_n}, 2'h1);
      {bus_dominant, high_voltage_wakeup} = 2'h3;
      settle(WUF + 12);
      {bus_dominant, high_voltage_wakeup} = 2'h0;
      chk({standby, rx_data}, 2'h2);
      settle(SLP - 30);
      chk({standby, tx_pullup_en}, 2'h2);
      settle(40);
      chk({standby, rx_data_oe_n}, 2'h1);
      {bus_dominant, high_voltage_wakeup} = 2'h3;
      settle(WUF + 12);
      {bus_dominant, high_voltage_wakeup} = 2'h0;
      cmd_mode = SWB_MODE_NORMAL;
      settle(SLP + 20);
      chk({standby, tx_pullup_en}, 2'h1);
   endtask

   task automatic t_ground;
      ground_lost = 1'b1;
      settle(12);
      chk({1'b0, load_path_closed}, 2'h0);
      ground_lost = 1'b0;
      settle(12);
      chk({1'b0, load_path_closed}, 2'h1);
   endtask

   // Main sequence
   initial begin
      settle(12);
      rstn = 1'b1;
      settle(4);
      t_reset;
      t_modes;
      t_rx;
      t_timeout;
      t_wake;
      t_ground;
      give_verdict;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      give_verdict;
   end
endmodule // swb_core_tb

bind swb_core swb_core_chk #(.TXTO_CYC(TXTO_CYC)) chk_i (.clk, .rstn, .tx_data, .mode_select_lo,
   .mode_select_hi, .rx_data, .rx_data_oe_n, .tx_pullup_en, .hs_drive, .shaping_en,
   .bus_line_drive, .standby, .tx_timed_out);
